// ### src/fllr_pkg.sv
package fllr_pkg;
  // Register offsets
  localparam logic [7:0] OFS_RAMP_B      = 8'h63;
  localparam logic [7:0] OFS_FLOOR1      = 8'h64;
  localparam logic [7:0] OFS_FLOOR2      = 8'h65;
  localparam logic [7:0] OFS_FLOOR3      = 8'h66;
  localparam logic [7:0] OFS_START_R1    = 8'h67;
  localparam logic [7:0] OFS_START_LOC   = 8'h68;
  localparam logic [7:0] OFS_START_R2    = 8'h69;
  localparam logic [7:0] OFS_CRIT_R1     = 8'h6A;
  localparam logic [7:0] OFS_CRIT_LOC    = 8'h6B;
  localparam logic [7:0] OFS_CRIT_R2     = 8'h6C;
  localparam logic [7:0] OFS_HYST_R1L    = 8'h6D;
  localparam logic [7:0] OFS_HYST_R2     = 8'h6E;
  localparam logic [7:0] OFS_CTRL        = 8'h78;
  localparam logic [7:0] OFS_IRQ_STAT    = 8'h79;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h7A;
  localparam logic [7:0] OFS_LOOP_STAT   = 8'h7B;
  // Reset values
  localparam logic [7:0] RST_RAMP_B      = 8'h00;
  localparam logic [7:0] RST_FLOOR       = 8'h80;
  localparam logic [7:0] RST_START       = 8'h5A;
  localparam logic [7:0] RST_CRIT        = 8'h64;
  localparam logic [7:0] RST_HYST_R1L    = 8'h44;
  localparam logic [7:0] RST_HYST_R2     = 8'h40;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  // Fields
  localparam int RAMP_CODE_LSB           = 4;
  localparam int CTRL_LOCK_BIT           = 0;
  localparam int CTRL_AUTO_BIT           = 1;
  localparam int CTRL_SLOW_BIT           = 2;
  localparam int CTRL_PINOUT_BIT         = 3;
  localparam logic [7:0] CRIT_DISABLED   = 8'h80;
  localparam logic [7:0] DUTY_FULL       = 8'hFF;
  // Ramp timing: 255 steps of one time slot each
  localparam int CLK_HZ                  = 25_000_000;
  localparam int RAMP_FAST_MS            = 37_500;
  localparam int RAMP_SLOW_MS            = 52_200;
  localparam int DUTY_STEPS              = 255;
  localparam longint SLOT_FAST_CYC =
    longint'(RAMP_FAST_MS) * CLK_HZ / 1000 / DUTY_STEPS;
  localparam longint SLOT_SLOW_CYC =
    longint'(RAMP_SLOW_MS) * CLK_HZ / 1000 / DUTY_STEPS;
endpackage

// ### src/fllr_top.sv
// Overview of operation
// - With the slow bit set, ramp codes give slot steps 1,2,3,4,8,12,24,48 on the 52.2 s base.
// - With the slow bit clear, the same codes run on the 37.5 s full-scale base.
// - Each output walks toward its target duty one slot at a time, except fail-safe, which jumps straight to full duty.
// - With lock set, writes to ramp, start, critical and hysteresis registers are dropped.
// - Floor duty code scales linearly, 0x00 stopped to 0xFF full.
// - In automatic mode the floor duty registers discard writes.
// - Above start temperature a fan runs at floor duty and rises with the span.
// - Below start the fan holds floor duty until start minus hysteresis.
// - Any channel above its critical limit forces every output to full duty.
// - A critical limit of 0x80 never triggers the fail-safe.
// - Full duty holds until temperature falls below critical minus hysteresis.
// - With the pin set as output, it is pulled low while the fail-safe holds full duty.
// - Hysteresis register 0x6D holds local in 3:0 and remote 1 in 7:4.
// - Remote 2 hysteresis sits in bits 7:4 of register 0x6E.
`timescale 1ns/1ps
`default_nettype none
module fllr_top #(
  parameter longint SLOT_FAST = fllr_pkg::SLOT_FAST_CYC,
  parameter longint SLOT_SLOW = fllr_pkg::SLOT_SLOW_CYC,
  parameter int     SPAN_SH   = 2
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Temperatures: 0 remote 1, 1 local, 2 remote 2
  input  wire logic [7:0] temp_r1,
  input  wire logic [7:0] temp_loc,
  input  wire logic [7:0] temp_r2,
  // Fan duties
  output logic      [7:0] duty_1,
  output logic      [7:0] duty_2,
  output logic      [7:0] duty_3,
  // Over-temperature pin
  input  wire logic       overtemp_pin_i,
  output logic            overtemp_pin_o,
  output logic            overtemp_pin_oe,
  // Interrupt
  output logic            irq
);
  logic [7:0] ramp_q, ctrl_q, mask_q, stat_q, rdata_q;
  logic [7:0] floor_q [3];
  logic [7:0] start_q [3];
  logic [7:0] crit_q  [3];
  logic [7:0] hyst_q, hyst2_q;
  logic [7:0] temp    [3];
  logic [3:0] hyst    [3];
  logic [2:0] run_q, hot_q;
  logic [7:0] duty_q  [3];
  logic [31:0] slot_cnt_q;
  logic [5:0] step;
  logic       slot_tick, any_hot, locked, auto_mode;
  logic [7:0] rd_mux;

  assign temp[0] = temp_r1;
  assign temp[1] = temp_loc;
  assign temp[2] = temp_r2;
  assign hyst[0] = hyst_q[7:4];
  assign hyst[1] = hyst_q[3:0];
  assign hyst[2] = hyst2_q[7:4];
  assign locked    = ctrl_q[fllr_pkg::CTRL_LOCK_BIT];
  assign auto_mode = ctrl_q[fllr_pkg::CTRL_AUTO_BIT];

  // Write decode
  wire wr_lockable = reg_wr && !locked;
  wire wr_floor_ok = reg_wr && !auto_mode;
  wire wr_ramp  = wr_lockable && reg_addr == fllr_pkg::OFS_RAMP_B;
  wire wr_hyst  = wr_lockable && reg_addr == fllr_pkg::OFS_HYST_R1L;
  wire wr_hyst2 = wr_lockable && reg_addr == fllr_pkg::OFS_HYST_R2;
  wire wr_ctrl  = reg_wr && reg_addr == fllr_pkg::OFS_CTRL;
  wire wr_mask  = reg_wr && reg_addr == fllr_pkg::OFS_IRQ_MASK;
  wire rd_stat  = reg_rd && reg_addr == fllr_pkg::OFS_IRQ_STAT;

  // Slot step by ramp code
  wire [2:0] ramp_code = ramp_q[fllr_pkg::RAMP_CODE_LSB +: 3];
  always_comb
  begin
    unique case (ramp_code)
      3'd0: step = 6'd1;
      3'd1: step = 6'd2;
      3'd2: step = 6'd3;
      3'd3: step = 6'd4;
      3'd4: step = 6'd8;
      3'd5: step = 6'd12;
      3'd6: step = 6'd24;
      3'd7: step = 6'd48;
    endcase
  end

  wire [31:0] slot_len = ctrl_q[fllr_pkg::CTRL_SLOW_BIT] ?
    32'(SLOT_SLOW) : 32'(SLOT_FAST);
  assign slot_tick = (slot_cnt_q >= slot_len - 32'h0000_0001);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      slot_cnt_q <= 32'h0000_0000;
    else if (slot_tick)
      slot_cnt_q <= 32'h0000_0000;
    else
      slot_cnt_q <= slot_cnt_q + 32'h0000_0001;
  end

  // Per-channel registers and loop
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_ch
      wire [7:0] ofs_fl = fllr_pkg::OFS_FLOOR1 + 8'(g);
      wire [7:0] ofs_st = fllr_pkg::OFS_START_R1 + 8'(g);
      wire [7:0] ofs_cr = fllr_pkg::OFS_CRIT_R1 + 8'(g);
      wire wr_fl = wr_floor_ok && reg_addr == ofs_fl;
      wire wr_st = wr_lockable && reg_addr == ofs_st;
      wire wr_cr = wr_lockable && reg_addr == ofs_cr;
      // Temperatures and limits are 1 degree per code
      wire [8:0] st_lo = {1'b0, start_q[g]} - {5'h00, hyst[g]};
      wire [8:0] cr_lo = {1'b0, crit_q[g]} - {5'h00, hyst[g]};
      wire crit_en = crit_q[g] != fllr_pkg::CRIT_DISABLED;
      wire over_st = temp[g] > start_q[g];
      wire under_st_h = st_lo[8] ? 1'b0 : ({1'b0, temp[g]} <= st_lo);
      wire over_cr = crit_en && temp[g] > crit_q[g];
      wire under_cr_h = cr_lo[8] ? 1'b0 : ({1'b0, temp[g]} < cr_lo);
      // Duty above start grows with span
      wire [8:0] above = {1'b0, temp[g]} - {1'b0, start_q[g]};
      wire [9:0] rise  = 10'({above, 1'b0} << SPAN_SH);
      wire [9:0] sum   = {2'b00, floor_q[g]} + rise;
      wire [7:0] curve = (over_st && !above[8]) ?
        ((sum > 10'h0FF) ? fllr_pkg::DUTY_FULL : sum[7:0]) : floor_q[g];
      wire [7:0] target = any_hot ? fllr_pkg::DUTY_FULL :
        (run_q[g] ? curve : 8'h00);
      wire [8:0] up = {1'b0, duty_q[g]} + {3'b000, step};
      wire [8:0] dn = {1'b0, duty_q[g]} - {3'b000, step};

      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          floor_q[g] <= fllr_pkg::RST_FLOOR;
          start_q[g] <= fllr_pkg::RST_START;
          crit_q[g]  <= fllr_pkg::RST_CRIT;
          run_q[g]   <= 1'b0;
          hot_q[g]   <= 1'b0;
          duty_q[g]  <= fllr_pkg::RST_FLOOR;
        end
        else
        begin
          if (wr_fl)
            floor_q[g] <= reg_wdata;
          if (wr_st)
            start_q[g] <= reg_wdata;
          if (wr_cr)
            crit_q[g] <= reg_wdata;
          // Run latch with hysteresis
          if (over_st)
            run_q[g] <= 1'b1;
          else if (under_st_h)
            run_q[g] <= 1'b0;
          // Critical latch with hysteresis
          if (over_cr)
            hot_q[g] <= 1'b1;
          else if (under_cr_h || !crit_en)
            hot_q[g] <= 1'b0;
          // Gradual move toward target
          if (any_hot)
            duty_q[g] <= fllr_pkg::DUTY_FULL;
          else if (slot_tick && duty_q[g] < target)
            duty_q[g] <= (up[8] || up[7:0] > target) ? target : up[7:0];
          else if (slot_tick && duty_q[g] > target)
            duty_q[g] <= (dn[8] || dn[7:0] < target) ? target : dn[7:0];
        end
      end
    end
  endgenerate

  assign any_hot = |hot_q;
  assign duty_1 = duty_q[0];
  assign duty_2 = duty_q[1];
  assign duty_3 = duty_q[2];

  // Pin is open drain: drive low only
  assign overtemp_pin_o  = 1'b0;
  assign overtemp_pin_oe = ctrl_q[fllr_pkg::CTRL_PINOUT_BIT] && any_hot;

  // Events: bit0 fail-safe entry, bit1 external pin low seen
  logic hot_d1_q, pin_d1_q;
  wire [7:0] ev = {6'h00,
    (!overtemp_pin_i && pin_d1_q && !overtemp_pin_oe),
    (any_hot && !hot_d1_q)};

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ramp_q   <= fllr_pkg::RST_RAMP_B;
      hyst_q   <= fllr_pkg::RST_HYST_R1L;
      hyst2_q  <= fllr_pkg::RST_HYST_R2;
      ctrl_q   <= fllr_pkg::RST_ZERO;
      mask_q   <= fllr_pkg::RST_ZERO;
      stat_q   <= fllr_pkg::RST_ZERO;
      rdata_q  <= fllr_pkg::RST_ZERO;
      hot_d1_q <= 1'b0;
      pin_d1_q <= 1'b1;
    end
    else
    begin
      if (wr_ramp)
        ramp_q <= reg_wdata;
      if (wr_hyst)
        hyst_q <= reg_wdata;
      if (wr_hyst2)
        hyst2_q <= {reg_wdata[7:4], 4'h0};
      if (wr_ctrl)
        ctrl_q <= {4'h0, reg_wdata[3:1], reg_wdata[0] | locked};
      if (wr_mask)
        mask_q <= reg_wdata;
      // Set wins over read clear
      stat_q   <= (rd_stat ? 8'h00 : stat_q) | ev;
      hot_d1_q <= any_hot;
      pin_d1_q <= overtemp_pin_i;
      rdata_q  <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign irq = |(stat_q & mask_q);

  // Read mux
  always_comb
  begin
    unique case (reg_addr)
      fllr_pkg::OFS_RAMP_B:    rd_mux = ramp_q;
      fllr_pkg::OFS_FLOOR1:    rd_mux = floor_q[0];
      fllr_pkg::OFS_FLOOR2:    rd_mux = floor_q[1];
      fllr_pkg::OFS_FLOOR3:    rd_mux = floor_q[2];
      fllr_pkg::OFS_START_R1:  rd_mux = start_q[0];
      fllr_pkg::OFS_START_LOC: rd_mux = start_q[1];
      fllr_pkg::OFS_START_R2:  rd_mux = start_q[2];
      fllr_pkg::OFS_CRIT_R1:   rd_mux = crit_q[0];
      fllr_pkg::OFS_CRIT_LOC:  rd_mux = crit_q[1];
      fllr_pkg::OFS_CRIT_R2:   rd_mux = crit_q[2];
      fllr_pkg::OFS_HYST_R1L:  rd_mux = hyst_q;
      fllr_pkg::OFS_HYST_R2:   rd_mux = hyst2_q;
      fllr_pkg::OFS_CTRL:      rd_mux = ctrl_q;
      fllr_pkg::OFS_IRQ_STAT:  rd_mux = stat_q;
      fllr_pkg::OFS_IRQ_MASK:  rd_mux = mask_q;
      fllr_pkg::OFS_LOOP_STAT: rd_mux = {2'b00, hot_q, run_q};
      default:                 rd_mux = 8'h00;
    endcase
  end
  assign reg_rdata = rdata_q;

  // Checks
  AST_FAILSAFE: assert property (@(posedge clk_sys) disable iff (!nrst)
    any_hot |=> (duty_1 == 8'hFF && duty_2 == 8'hFF && duty_3 == 8'hFF))
    else $error("fail-safe not at full duty");
  AST_LOCK_RAMP: assert property (@(posedge clk_sys) disable iff (!nrst)
    (locked && reg_wr && reg_addr == 8'h63) |=> $stable(ramp_q))
    else $error("locked ramp register changed");
  AST_LOCK_START: assert property (@(posedge clk_sys) disable iff (!nrst)
    (locked && reg_wr && reg_addr == 8'h68) |=> $stable(start_q[1]))
    else $error("locked start register changed");
  AST_AUTO_FLOOR: assert property (@(posedge clk_sys) disable iff (!nrst)
    (auto_mode && reg_wr && reg_addr == 8'h64) |=> $stable(floor_q[0]))
    else $error("floor written in automatic mode");
  AST_CRIT_OFF: assert property (@(posedge clk_sys) disable iff (!nrst)
    (crit_q[0] == 8'h80) |=> !hot_q[0])
    else $error("disabled critical limit triggered");
  AST_PIN: assert property (@(posedge clk_sys) disable iff (!nrst)
    overtemp_pin_oe |-> (any_hot && ctrl_q[3]))
    else $error("pin driven without cause");
  AST_RAMP_STEP: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!any_hot && !$past(any_hot) && !$past(slot_tick)) |-> $stable(duty_1))
    else $error("duty moved off a slot");
  AST_HOT_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
    (hot_q[1] && crit_q[1] != 8'h80 && temp_loc >= crit_q[1])
      |=> hot_q[1])
    else $error("fail-safe released early");
  // Local run latch held while above start minus its own field
  sequence s_loc_run_hold;
    run_q[1] &&
      ({1'b0, temp_loc} + {5'h00, hyst_q[3:0]} > {1'b0, start_q[1]});
  endsequence
  AST_HYST_MAP: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_loc_run_hold |=> run_q[1])
    else $error("local hysteresis field misapplied");

  // Remote 2 run latch uses the upper field of its own register
  sequence s_r2_run_hold;
    run_q[2] &&
      ({1'b0, temp_r2} + {5'h00, hyst2_q[7:4]} > {1'b0, start_q[2]});
  endsequence
  AST_HYST2_MAP: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_r2_run_hold |=> run_q[2])
    else $error("remote 2 hysteresis field misapplied");

  // Local channel over its enabled limit
  sequence s_loc_over;
    crit_q[1] != 8'h80 && temp_loc > crit_q[1];
  endsequence
  AST_FAILSAFE_ENTRY: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_loc_over |=> (hot_q[1] && any_hot))
    else $error("fail-safe not entered");

  // Remote 1 channel over its enabled limit
  sequence s_r1_over;
    crit_q[0] != 8'h80 && temp_r1 > crit_q[0];
  endsequence
  AST_R1_ENTRY: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_r1_over |=> hot_q[0])
    else $error("remote 1 fail-safe not entered");

  // Local channel well below limit minus hysteresis
  sequence s_loc_cool;
    ({1'b0, temp_loc} + {5'h00, hyst_q[3:0]} < {1'b0, crit_q[1]});
  endsequence
  AST_HOT_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_loc_cool |=> !hot_q[1])
    else $error("fail-safe not released");

  // Local channel at or below start minus hysteresis
  sequence s_loc_idle;
    ({1'b0, temp_loc} + {5'h00, hyst_q[3:0]} <= {1'b0, start_q[1]});
  endsequence
  AST_RUN_OFF: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_loc_idle |=> !run_q[1])
    else $error("fan loop not stopped");

  AST_RUN_ON: assert property (@(posedge clk_sys) disable iff (!nrst)
    (temp_loc > start_q[1]) |=> run_q[1])
    else $error("fan loop not started");

  AST_PIN_ON: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ctrl_q[3] && any_hot) |-> overtemp_pin_oe)
    else $error("pin not driven in fail-safe");
  AST_PIN_LOW: assert property (@(posedge clk_sys) disable iff (!nrst)
    !overtemp_pin_o)
    else $error("pin driven high");

  AST_LOCK_CRIT: assert property (@(posedge clk_sys) disable iff (!nrst)
    (locked && reg_wr && reg_addr == 8'h6B) |=> $stable(crit_q[1]))
    else $error("locked critical register changed");
  AST_LOCK_HYST: assert property (@(posedge clk_sys) disable iff (!nrst)
    (locked && reg_wr && reg_addr == 8'h6D) |=> $stable(hyst_q))
    else $error("locked hysteresis register changed");
  AST_LOCK_HYST2: assert property (@(posedge clk_sys) disable iff (!nrst)
    (locked && reg_wr && reg_addr == 8'h6E) |=> $stable(hyst2_q))
    else $error("locked remote 2 hysteresis changed");
  AST_RAMP_WR: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!locked && reg_wr && reg_addr == 8'h63)
      |=> (ramp_q == $past(reg_wdata)))
    else $error("unlocked ramp write lost");
  AST_FLOOR_WR: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!auto_mode && reg_wr && reg_addr == 8'h64)
      |=> (floor_q[0] == $past(reg_wdata)))
    else $error("manual floor write lost");

  // Duty moves at most one programmed step per clock
  AST_STEP_SIZE: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!any_hot && !$past(any_hot)) |->
      (({1'b0, duty_1} <= {1'b0, $past(duty_1)} + {3'b000, $past(step)})
      && ({1'b0, duty_1} + {3'b000, $past(step)} >= {1'b0, $past(duty_1)})))
    else $error("duty jumped past one step");

  AST_EVENT_SET: assert property (@(posedge clk_sys) disable iff (!nrst)
    (any_hot && !hot_d1_q) |=> stat_q[0])
    else $error("fail-safe event lost");
  AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (!nrst)
    !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data without a read");
endmodule
`default_nettype wire

// ### dv/fllr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module fllr_pin_model (
  // Device side
  input  wire logic dev_oe,
  // Board side
  input  wire logic ext_low,
  output logic      pin_level
);
  // Pull-up: low while anyone pulls
  assign pin_level = ~(dev_oe | ext_low);
endmodule
`default_nettype wire

// ### dv/fan_loop_limit_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fan_loop_limit_registers_tb;
  logic       clk_sys   = 1'b0;
  logic       nrst      = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] temp_r1   = 8'h14;
  logic [7:0] temp_loc  = 8'h14;
  logic [7:0] temp_r2   = 8'h14;
  logic       ext_low   = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] duty_1;
  logic [7:0] duty_2;
  logic [7:0] duty_3;
  logic       pin_i;
  logic       pin_oe;
  logic       irq;
  logic [7:0] v;
  int         n_fail          = 0;
  int         samples_checked = 0;
  logic [7:0] rst_tab [12] = '{8'h00, 8'h80, 8'h80, 8'h80, 8'h5A, 8'h5A,
                               8'h5A, 8'h64, 8'h64, 8'h64, 8'h44, 8'h40};

  fllr_top #(.SLOT_FAST(4), .SLOT_SLOW(6), .SPAN_SH(2)) u_fllr_top (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .temp_r1(temp_r1), .temp_loc(temp_loc),
    .temp_r2(temp_r2), .duty_1(duty_1), .duty_2(duty_2), .duty_3(duty_3),
    .overtemp_pin_i(pin_i), .overtemp_pin_o(), .overtemp_pin_oe(pin_oe),
    .irq(irq));
  fllr_pin_model u_fllr_pin_model (
    .dev_oe(pin_oe), .ext_low(ext_low), .pin_level(pin_i));

  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd(a, v);
    check(v, e, "register read");
  endtask

  task automatic wait_change(output logic [7:0] n);
    logic [7:0] p;
    p = duty_1;
    n = 8'h00;
    while (duty_1 === p && n < 8'hC8)
    begin
      @(posedge clk_sys);
      #1 n = n + 8'h01;
    end
  endtask

  task automatic ramp_check(input logic [7:0] ctrl, input logic [2:0] code,
                            input logic [7:0] step, input logic [7:0] gap);
    logic [7:0] n;
    logic [7:0] prev;
    wr(8'h78, ctrl);
    wr(8'h63, {1'b0, code, 4'h0});
    temp_loc <= 8'h65;
    repeat (8) @(posedge clk_sys);
    #1;
    check(duty_1, 8'hFF, "duty_1 fail-safe");
    check(duty_2, 8'hFF, "duty_2 fail-safe");
    check(duty_3, 8'hFF, "duty_3 fail-safe");
    check({7'h00, pin_oe}, 8'h01, "pin drive");
    temp_loc <= 8'h63;
    repeat (10) @(posedge clk_sys);
    #1 check(duty_2, 8'hFF, "duty_2 held");
    temp_loc <= 8'h14;
    wait_change(n);
    check({7'h00, pin_oe}, 8'h00, "pin released");
    prev = duty_1;
    wait_change(n);
    check(prev - duty_1, step, "ramp step");
    check(n, gap, "slot length");
  endtask

  task automatic close_out();
    $display("Counts: %0d checked, %0d failed", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #400_000;
    n_fail++;
    close_out();
  end

  initial
  begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 12; i++)
      rd_chk(8'h63 + 8'(i), rst_tab[i]);
    rd_chk(8'h50, 8'h00);
    $display("Test reset values done");
    wr(8'h6D, 8'h5A);
    rd_chk(8'h6D, 8'h5A);
    wr(8'h6E, 8'hFF);
    rd_chk(8'h6E, 8'hF0);
    wr(8'h64, 8'h40);
    rd_chk(8'h64, 8'h40);
    wr(8'h78, 8'h02);
    wr(8'h64, 8'h11);
    rd_chk(8'h64, 8'h40);
    $display("Test field access done");
    wr(8'h67, 8'hA0);
    wr(8'h6A, 8'h80);
    temp_r1 <= 8'h90;
    repeat (20) @(posedge clk_sys);
    #1 check({7'h00, duty_1 === 8'hFF}, 8'h00, "disabled limit");
    $display("Test disabled limit done");
    wr(8'h7A, 8'h00);
    ramp_check(8'h0A, 3'd0, 8'd1, 8'd4);
    check({7'h00, irq}, 8'h00, "irq masked");
    wr(8'h7A, 8'h01);
    #1 check({7'h00, irq}, 8'h01, "irq raised");
    rd(8'h79, v);
    check({7'h00, v[0]}, 8'h01, "fail-safe event");
    #1 check({7'h00, irq}, 8'h00, "irq cleared");
    ext_low <= 1'b1;
    repeat (2) @(posedge clk_sys);
    ext_low <= 1'b0;
    rd(8'h79, v);
    check({7'h00, v[1]}, 8'h01, "external pin event");
    ramp_check(8'h0E, 3'd7, 8'd48, 8'd6);
    $display("Test ramp and fail-safe done");
    wr(8'h78, 8'h0F);
    wr(8'h63, 8'h30);
    rd_chk(8'h63, 8'h70);
    wr(8'h6B, 8'h10);
    rd_chk(8'h6B, 8'h64);
    wr(8'h6E, 8'h00);
    rd_chk(8'h6E, 8'hF0);
    $display("Test lock done");
    close_out();
  end
endmodule
`default_nettype wire
